/* bench/hdlc_fifo_host_status_assertions.sv */
`timescale 1ns/1ps
module hdlc_fifo_host_status_chk (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Host port
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Engine lanes
	input wire logic [1:0] tx_req_i,
	input wire logic [1:0] tx_strobe_o,
	input wire logic [1:0] tx_abort_o,
	input wire logic [1:0] rx_ready_o
);
	// One domain only
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_rdata_held: assert property (!rd_i |=> $stable(rdata_o))
		else $error("read data moved without a read");
	a_info_spare: assert property (rd_i && addr_i[7:1] == 7'h17 |=> rdata_o[7:6] == 2'b00)
		else $error("info spare bits set");
	a_event_spare: assert property (rd_i && addr_i == 8'h2d |=> rdata_o[7:4] == 4'h0)
		else $error("event spare bits set");
	a_space_range: assert property (rd_i && addr_i == 8'h9f |=> rdata_o <= 8'h80)
		else $error("tx space above fifo size");
	a_status_code: assert property (rd_i && addr_i == 8'h2e |=> rdata_o[2:0] <= 3'h5)
		else $error("undefined packet status");
	// Every strobe or abort answers a request one edge earlier
	a_tx_cause: assert property (|(tx_strobe_o | tx_abort_o)
		|-> ((tx_strobe_o | tx_abort_o) & ~$past(tx_req_i)) == 2'b00)
		else $error("tx pulse without request");
	a_tx_excl: assert property ((tx_strobe_o & tx_abort_o) == 2'b00)
		else $error("byte and abort together");
	a_ready_reset: assert property ($fell(srst_i) |-> rx_ready_o == 2'b11)
		else $error("rx not ready after reset");
	// Main scenarios reached
	c_abort: cover property (tx_abort_o[0]);
	c_lane2: cover property (tx_strobe_o[1]);
	c_pop: cover property (rd_i && addr_i == 8'h9e);
endmodule : hdlc_fifo_host_status_chk
bind hdlc_fifo_host_status hdlc_fifo_host_status_chk chk (.clk_i, .srst_i, .addr_i, .rd_i,
	.rdata_o, .tx_req_i, .tx_strobe_o, .tx_abort_o, .rx_ready_o);

/* bench/hdlc_host_model.sv */
`timescale 1ns/1ps
module hdlc_host_model (
	// Clock
	input wire logic clk_i,
	// Parallel port toward the device
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i
);
	// Bus idle from time zero
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 8'h00;
	end
	// One write strobe, held a full cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
	endtask : wr
	// Read data is registered, so wait one more edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		@(posedge clk_i);
		#1;
		d = rdata_i;
	endtask : rd
endmodule : hdlc_host_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import hdlc_fifo_pkg::*;
	// Clock, reset, host wires
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [7:0] addr_i, wdata_i, rdata_o;
	logic wr_i, rd_i, irq_o;
	// Engine lanes, idle at time zero
	logic [1:0] tx_req_i = '0;
	logic [1:0] tx_msg_done_i = '0;
	logic [1:0][7:0] tx_byte_o;
	logic [1:0] tx_strobe_o, tx_abort_o, rx_ready_o;
	logic [1:0] rx_valid_i = '0;
	logic [1:0] rx_first_i = '0;
	logic [1:0] rx_last_i = '0;
	logic [1:0][7:0] rx_byte_i = '0;
	logic [1:0][2:0] rx_status_i = '0;
	logic [2:0] codes [3] = '{3'h2, 3'h3, 3'h5};
	logic [7:0] v;
	int n_mismatch = 0;
	int tests_run = 0;
	always #5 clk_i = ~clk_i;
	hdlc_host_model host (.clk_i(clk_i), .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i),
		.wdata_o(wdata_i), .rdata_i(rdata_o));
	hdlc_fifo_host_status dut (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_i(wr_i),
		.rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .irq_o(irq_o),
		.tx_req_i(tx_req_i), .tx_byte_o(tx_byte_o), .tx_strobe_o(tx_strobe_o),
		.tx_abort_o(tx_abort_o), .tx_msg_done_i(tx_msg_done_i), .rx_valid_i(rx_valid_i),
		.rx_byte_i(rx_byte_i), .rx_first_i(rx_first_i), .rx_last_i(rx_last_i),
		.rx_status_i(rx_status_i), .rx_ready_o(rx_ready_o));
	// Verdict, the only exit
	task automatic final_report();
		if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	// Byte compare
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Register read and compare
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
		host.rd(a, v);
		chk(nm, e, v);
	endtask : rdc
	// Receive engine offers one byte; data line scrambled once released
	task automatic rxp(input int c, input logic [7:0] b, input logic f, input logic l,
		input logic [2:0] s);
		@(negedge clk_i);
		rx_valid_i[c] = 1'b1;
		rx_byte_i[c] = b;
		rx_first_i[c] = f;
		rx_last_i[c] = l;
		rx_status_i[c] = s;
		@(negedge clk_i);
		rx_valid_i[c] = 1'b0;
		rx_byte_i[c] = ~b;
	endtask : rxp
	// Transmit engine asks for a byte; the one-cycle answer is looked at while it stands
	task automatic txp(input int c, input logic es, input logic ea, input logic [7:0] eb);
		@(negedge clk_i);
		tx_req_i[c] = 1'b1;
		@(posedge clk_i);
		#1;
		chk("tx strobe", {7'h0, es}, {7'h0, tx_strobe_o[c]});
		chk("tx abort", {7'h0, ea}, {7'h0, tx_abort_o[c]});
		if (es) chk("tx byte", eb, tx_byte_o[c]);
		@(negedge clk_i);
		tx_req_i[c] = 1'b0;
	endtask : txp
	// Watchdog, far beyond the expected run of under two thousand cycles
	initial begin
		#300000;
		n_mismatch++;
		final_report();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_i);
		@(negedge clk_i);
		srst_i = 1'b0;
		rdc(8'h2e, 8'h28, "info1 reset");
		rdc(8'h2f, 8'h28, "info2 reset");
		rdc(8'h9c, 8'h80, "count1 reset");
		// Controller 1: short message then underrun
		for (int i = 0; i < 3; i++) host.wr(8'h9d, 8'ha0 + i[7:0]);
		rdc(8'h9f, 8'h7d, "space1");
		rdc(8'h2e, 8'h08, "info1 tx");
		for (int i = 0; i < 3; i++) txp(0, 1'b1, 1'b0, 8'ha0 + i[7:0]);
		txp(0, 1'b0, 1'b1, 8'h00);
		rdc(8'h2d, 8'h02, "underrun1");
		rdc(8'h2d, 8'h00, "underrun1 clr");
		// Controller 2: fill until refused, drain, clean end
		for (int i = 0; i < 129; i++) host.wr(8'had, i[7:0]);
		rdc(8'h2f, 8'h18, "info2 full");
		rdc(8'haf, 8'h00, "space2 full");
		for (int i = 0; i < 128; i++) txp(1, 1'b1, 1'b0, i[7:0]);
		@(negedge clk_i);
		tx_msg_done_i[1] = 1'b1;
		@(negedge clk_i);
		tx_msg_done_i[1] = 1'b0;
		txp(1, 1'b0, 1'b0, 8'h00);
		rdc(8'h2d, 8'h00, "no underrun2");
		rdc(8'h22, 8'h43, "status2 end");
		rdc(8'h22, 8'h03, "status2 clr");
		// Controller 1 receive, packet end unmasked
		host.wr(8'h21, 8'h20);
		for (int i = 0; i < 4; i++) rxp(0, 8'h30 + i[7:0], i == 0, i == 3, 3'h1);
		repeat (2) @(negedge clk_i);
		chk("irq set", 8'h01, {7'h0, irq_o});
		rdc(8'h2d, 8'h01, "open byte");
		rdc(8'h9c, 8'h04, "count1 end");
		rdc(8'h20, 8'h37, "status1");
		chk("irq clr", 8'h00, {7'h0, irq_o});
		for (int i = 0; i < 4; i++) rdc(8'h9e, 8'h30 + i[7:0], "rx byte");
		rdc(8'h2e, 8'h29, "packet ok");
		host.wr(8'h21, 8'h00);
		// Remaining closing codes, masked
		for (int i = 0; i < 3; i++) begin
			rxp(0, 8'h77, 1'b1, 1'b1, codes[i]);
			chk("irq masked", 8'h00, {7'h0, irq_o});
			rdc(8'h9e, 8'h77, "rx one");
			rdc(8'h2e, {5'h05, codes[i]}, "closing code");
		end
		// Unfinished message, then overrun
		rxp(0, 8'h11, 1'b1, 1'b0, 3'h0);
		rxp(0, 8'h22, 1'b0, 1'b0, 3'h0);
		rdc(8'h9c, 8'h82, "count1 open");
		rdc(8'h9e, 8'h11, "rx a");
		rdc(8'h9e, 8'h22, "rx b");
		rdc(8'h2e, 8'h28, "in progress");
		for (int i = 0; i < 128; i++) rxp(0, i[7:0], 1'b0, 1'b0, 3'h0);
		chk("rx ready", 8'h00, {7'h0, rx_ready_o[0]});
		host.rd(8'h20, v);
		rxp(0, 8'hee, 1'b0, 1'b1, 3'h1);
		rdc(8'h20, 8'h2f, "status1 overrun");
		for (int i = 0; i < 128; i++) rdc(8'h9e, i[7:0], "rx fill");
		rdc(8'h2e, 8'h2c, "overrun code");
		final_report();
	end
endmodule : tb_top

/* core/fifo_buffer.sv */
`timescale 1ns/1ps
module fifo_buffer #(
	parameter int W = 8,
	parameter int D = 8,
	parameter int AW = $clog2(D)
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Filling side
	input wire logic push_valid_i,
	input wire logic [W-1:0] push_data_i,
	output logic push_ready_o,
	// Draining side
	output logic pop_valid_o,
	input wire logic pop_ready_i,
	output logic [W-1:0] pop_data_o,
	// Fill level
	output logic [AW:0] count_o
);
	logic [W-1:0] mem [D]; // Storage, flip-flops
	logic [AW-1:0] wr_ptr; // Depth is a power of two, so pointers wrap freely
	logic [AW-1:0] rd_ptr;
	logic do_push;
	logic do_pop;
	logic [AW:0] next_count;

	assign do_push = push_valid_i & push_ready_o;
	assign do_pop = pop_valid_o & pop_ready_i;
	assign pop_data_o = mem[rd_ptr];

	// Next fill level
	always_comb begin
		next_count = count_o;
		if (do_push && !do_pop) begin
			next_count = count_o + (AW+1)'(1);
		end else if (do_pop && !do_push) begin
			next_count = count_o - (AW+1)'(1);
		end
	end

	// Level, pointers and registered full/empty
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			count_o <= '0;
			wr_ptr <= '0;
			rd_ptr <= '0;
			push_ready_o <= 1'b1;
			pop_valid_o <= 1'b0;
		end else begin
			count_o <= next_count;
			push_ready_o <= (next_count != (AW+1)'(D));
			pop_valid_o <= (next_count != '0);
			if (do_push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
		end
	end

	// Data write, no reset needed on payload
	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem[wr_ptr] <= push_data_i;
		end
	end
endmodule : fifo_buffer

/* core/hdlc_fifo_host_status.sv */
`timescale 1ns/1ps
`include "hdlc_fifo_params.svh"
module hdlc_fifo_host_status
	import hdlc_fifo_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// Host parallel port
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	output logic irq_o,
	// Transmit engine side, one lane per controller
	input wire logic [1:0] tx_req_i,
	output wire logic [1:0][7:0] tx_byte_o,
	output wire logic [1:0] tx_strobe_o,
	output wire logic [1:0] tx_abort_o,
	input wire logic [1:0] tx_msg_done_i,
	// Receive engine side, one lane per controller
	input wire logic [1:0] rx_valid_i,
	input wire logic [1:0][7:0] rx_byte_i,
	input wire logic [1:0] rx_first_i,
	input wire logic [1:0] rx_last_i,
	input wire logic [1:0][2:0] rx_status_i,
	output wire logic [1:0] rx_ready_o
);
	// Per-controller values seen by the read mux
	byte_t sr_val [2];
	byte_t info_val [2];
	byte_t rxcnt_val [2];
	byte_t rxdata_val [2];
	byte_t txspace_val [2];
	logic [1:0] open_flag; // Live opening-byte flags
	logic [1:0] udr_flag; // Latched underrun flags
	logic [1:0] irq_any;
	byte_t next_rdata;
	logic rd_event; // Host reads shared event register

	assign rd_event = rd_i && (addr_i == `OFS_EVENT);

	for (genvar g = 0; g < 2; g++) begin : gen_ctl
		localparam byte_t A_STATUS = (g == 0) ? `OFS_STATUS0 : `OFS_STATUS1;
		localparam byte_t A_MASK = (g == 0) ? `OFS_MASK0 : `OFS_MASK1;
		localparam byte_t A_TXDATA = (g == 0) ? `OFS_TXDATA0 : `OFS_TXDATA1;
		localparam byte_t A_RXDATA = (g == 0) ? `OFS_RXDATA0 : `OFS_RXDATA1;

		logic [6:0] mask; // Interrupt enables
		logic [6:4] ev_lat; // Latched packet events
		logic [3:0] cond; // Live FIFO conditions
		logic [3:0] cond_d; // Delayed copy for edge detect
		logic udr; // Latched underrun
		pkt_status_t pkt_status;
		logic in_msg; // Transmit message under way
		byte_t tx_byte;
		logic tx_strobe;
		logic tx_abort;
		logic drop; // Discarding rest of overrun packet
		byte_t tail_len; // Bytes of packet being received
		byte_t consumed; // Bytes of head message already read
		// Transmit FIFO
		logic tx_push_ready;
		logic tx_pop_valid;
		logic tx_pop;
		byte_t tx_head;
		byte_t tx_count;
		// Receive FIFO: first, last, status, byte
		logic rx_push_valid;
		logic rx_push_ready;
		logic rx_pop_valid;
		logic rx_pop;
		logic [12:0] rx_head;
		byte_t rx_count;
		logic rx_acc;
		logic rx_ovr;
		logic eff_drop;
		// Length queue of messages ended inside the receive FIFO
		logic len_push;
		byte_t len_in;
		logic len_push_ready;
		logic len_valid;
		logic len_pop;
		byte_t len_head;
		logic [3:0] len_count;
		logic msg_end; // Popped byte closes the head message
		logic wr_tx;
		logic rd_sr;
		byte_t remain;

		assign wr_tx = wr_i && (addr_i == A_TXDATA);
		assign rd_sr = rd_i && (addr_i == A_STATUS);
		assign rx_pop = rd_i && (addr_i == A_RXDATA) && rx_pop_valid;
		assign tx_pop = tx_req_i[g] && tx_pop_valid;

		// Bytes after an overrun are dropped until a new opening byte
		assign eff_drop = drop && !rx_first_i[g];
		// A closing byte also needs room in the length queue
		assign rx_push_valid = rx_valid_i[g] && !eff_drop && (len_push_ready || !rx_last_i[g]);
		assign rx_acc = rx_push_valid && rx_push_ready;
		assign rx_ovr = rx_valid_i[g] && !eff_drop && !rx_acc;
		assign len_push = (rx_acc && rx_last_i[g]) || (rx_ovr && !drop && tail_len != 8'h00);
		assign len_in = rx_acc ? tail_len + 8'h01 : tail_len;
		assign msg_end = rx_pop && len_valid && (consumed + 8'h01 == len_head);
		assign len_pop = msg_end;

		fifo_buffer #(.W(8), .D(`DATA_DEPTH)) u_tx_fifo (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.push_valid_i(wr_tx),
			.push_data_i(wdata_i),
			.push_ready_o(tx_push_ready),
			.pop_valid_o(tx_pop_valid),
			.pop_ready_i(tx_req_i[g]),
			.pop_data_o(tx_head),
			.count_o(tx_count)
		);

		fifo_buffer #(.W(13), .D(`DATA_DEPTH)) u_rx_fifo (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.push_valid_i(rx_push_valid),
			.push_data_i({rx_first_i[g], rx_last_i[g], rx_status_i[g], rx_byte_i[g]}),
			.push_ready_o(rx_push_ready),
			.pop_valid_o(rx_pop_valid),
			.pop_ready_i(rx_pop),
			.pop_data_o(rx_head),
			.count_o(rx_count)
		);

		fifo_buffer #(.W(8), .D(`LEN_DEPTH)) u_len_fifo (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.push_valid_i(len_push),
			.push_data_i(len_in),
			.push_ready_o(len_push_ready),
			.pop_valid_o(len_valid),
			.pop_ready_i(len_pop),
			.pop_data_o(len_head),
			.count_o(len_count)
		);

		// Live conditions: high mark, not empty, low mark, not full
		assign cond[`BIT_TNF] = tx_push_ready;
		assign cond[`BIT_TX_BELOW_LOW_MARK] = (tx_count < `TX_LOW_MARK);
		assign cond[`BIT_RNE] = rx_pop_valid;
		assign cond[`BIT_RX_ABOVE_HIGH_MARK] = (rx_count > `RX_HIGH_MARK);

		// Mask register, written by host
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				mask <= 7'h00;
			end else if (wr_i && addr_i == A_MASK) begin
				mask <= wdata_i[6:0];
			end
		end

		// Edge detect for condition interrupts
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				cond_d <= 4'h0;
			end else begin
				cond_d <= cond;
			end
		end

		// Condition rises only, events while latched and enabled
		assign irq_any[g] = |(cond & ~cond_d & mask[3:0])
			| |(ev_lat & mask[6:4]);

		// Latched packet events; a new event beats the read clear
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				ev_lat <= 3'h0;
			end else begin
				ev_lat <= (ev_lat & {3{!rd_sr}})
					| {tx_msg_done_i[g],
					(rx_acc && rx_last_i[g]) || (rx_ovr && !drop),
					rx_acc && rx_first_i[g]};
			end
		end

		// Overrun drop state
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				drop <= 1'b0;
			end else if (rx_ovr) begin
				drop <= 1'b1;
			end else if (rx_valid_i[g] && rx_first_i[g]) begin
				drop <= 1'b0;
			end
		end

		// Length of the packet now arriving
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				tail_len <= 8'h00;
			end else if (len_push || rx_ovr) begin
				tail_len <= 8'h00;
			end else if (rx_acc) begin
				tail_len <= tail_len + 8'h01;
			end
		end

		// Bytes already read from the head message
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				consumed <= 8'h00;
			end else if (msg_end) begin
				consumed <= 8'h00;
			end else if (rx_pop) begin
				// Count before the end is known too, else an open head message never closes
				consumed <= consumed + 8'h01;
			end
		end

		// Status as of the most recent receive data read, or of an overrun with nothing buffered
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				pkt_status <= PKT_IN_PROGRESS;
			end else if (rx_ovr && !drop && tail_len == 8'h00) begin
				pkt_status <= PKT_OVERRUN; // Nothing buffered to carry it
			end else if (msg_end) begin
				// Closing byte carries the engine code, else overrun cut
				pkt_status <= rx_head[11] ? pkt_status_t'(rx_head[10:8])
					: PKT_OVERRUN;
			end else if (rx_pop) begin
				pkt_status <= PKT_IN_PROGRESS;
			end
		end

		// Transmit engine handshake and underrun abort
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				in_msg <= 1'b0;
				tx_byte <= 8'h00;
				tx_strobe <= 1'b0;
				tx_abort <= 1'b0;
			end else begin
				tx_strobe <= tx_pop;
				tx_abort <= 1'b0;
				if (tx_pop) begin
					tx_byte <= tx_head;
					in_msg <= 1'b1;
				end else if (tx_req_i[g] && in_msg) begin
					tx_abort <= 1'b1;
					in_msg <= 1'b0;
				end
				if (tx_msg_done_i[g]) begin
					in_msg <= 1'b0;
				end
			end
		end

		// Underrun flag; set wins over the read clear
		always_ff @(posedge clk_i) begin
			if (srst_i) begin
				udr <= 1'b0;
			end else if (tx_req_i[g] && !tx_pop_valid && in_msg) begin
				udr <= 1'b1;
			end else if (rd_event) begin
				udr <= 1'b0;
			end
		end

		// Bytes to the next message end, or all bytes when none ended
		assign remain = len_valid ? len_head - consumed : rx_count;

		assign sr_val[g] = {1'b0, ev_lat, cond};
		assign info_val[g] = {2'b00, !tx_pop_valid, !tx_push_ready,
			!rx_pop_valid, pkt_status};
		assign rxcnt_val[g] = {!len_valid,
			(remain > `COUNT_CAP) ? 7'(`COUNT_CAP) : remain[6:0]};
		assign rxdata_val[g] = rx_pop_valid ? rx_head[7:0] : 8'h00;
		assign txspace_val[g] = 8'(`DATA_DEPTH) - tx_count;
		assign open_flag[g] = rx_pop_valid && rx_head[12];
		assign udr_flag[g] = udr;
		assign tx_byte_o[g] = tx_byte;
		assign tx_strobe_o[g] = tx_strobe;
		assign tx_abort_o[g] = tx_abort;
		assign rx_ready_o[g] = rx_push_ready;
	end

	// Read mux; unmapped and write-only addresses read zero
	always_comb begin
		next_rdata = `REG_RESET;
		case (addr_i)
			`OFS_STATUS0: next_rdata = sr_val[0];
			`OFS_STATUS1: next_rdata = sr_val[1];
			`OFS_MASK0: next_rdata = {1'b0, gen_ctl[0].mask};
			`OFS_MASK1: next_rdata = {1'b0, gen_ctl[1].mask};
			`OFS_EVENT: next_rdata = {4'h0, udr_flag[1], open_flag[1],
				udr_flag[0], open_flag[0]};
			`OFS_INFO0: next_rdata = info_val[0];
			`OFS_INFO1: next_rdata = info_val[1];
			`OFS_RXCNT0: next_rdata = rxcnt_val[0];
			`OFS_RXCNT1: next_rdata = rxcnt_val[1];
			`OFS_RXDATA0: next_rdata = rxdata_val[0];
			`OFS_RXDATA1: next_rdata = rxdata_val[1];
			`OFS_TXSPACE0: next_rdata = txspace_val[0];
			`OFS_TXSPACE1: next_rdata = txspace_val[1];
			default: next_rdata = `REG_RESET;
		endcase
	end

	// Read data held until the next read
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_o <= `REG_RESET;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end
	end

	// Interrupt request, any controller
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |irq_any;
		end
	end
endmodule : hdlc_fifo_host_status

/* core/hdlc_fifo_params.svh */
`ifndef HDLC_FIFO_PARAMS_SVH
`define HDLC_FIFO_PARAMS_SVH
// Register offsets, controller 1 then controller 2
`define OFS_STATUS0 8'h20
`define OFS_MASK0 8'h21
`define OFS_STATUS1 8'h22
`define OFS_MASK1 8'h23
`define OFS_EVENT 8'h2d
`define OFS_INFO0 8'h2e
`define OFS_INFO1 8'h2f
`define OFS_RXCNT0 8'h9c
`define OFS_TXDATA0 8'h9d
`define OFS_RXDATA0 8'h9e
`define OFS_TXSPACE0 8'h9f
`define OFS_RXCNT1 8'hac
`define OFS_TXDATA1 8'had
`define OFS_RXDATA1 8'hae
`define OFS_TXSPACE1 8'haf
// Reset value of the read data output, also read at unmapped addresses
`define REG_RESET 8'h00
// Status and mask bit positions
`define BIT_TNF 0
`define BIT_TX_BELOW_LOW_MARK 1
`define BIT_RNE 2
`define BIT_RX_ABOVE_HIGH_MARK 3
`define BIT_RPS 4
`define BIT_RPE 5
`define BIT_TX_MESSAGE_DONE_FLAG 6
// Event register bit positions, controller 2 adds two
`define BIT_OPEN 0
`define BIT_UDR 1
// Information register bit positions
`define BIT_RX_FIFO_EMPTY 3
`define BIT_TX_FIFO_FULL 4
`define BIT_TX_FIFO_EMPTY 5
// Sizes and watermarks
`define DATA_DEPTH 128
`define LEN_DEPTH 8
`define TX_LOW_MARK 8'h10
`define RX_HIGH_MARK 8'h40
`define COUNT_CAP 8'h7f
`endif

/* core/hdlc_fifo_pkg.sv */
package hdlc_fifo_pkg;
	// Receive packet status codes
	typedef enum logic [2:0] {
		PKT_IN_PROGRESS = 3'h0,
		PKT_OK = 3'h1,
		PKT_CRC_ERROR = 3'h2,
		PKT_ABORT = 3'h3,
		PKT_OVERRUN = 3'h4,
		PKT_TOO_SHORT = 3'h5
	} pkt_status_t;
	typedef logic [7:0] byte_t;
endpackage : hdlc_fifo_pkg
